/* core/rss_exec.sv */
// Execution unit for the return, set-bit, set-flag and skip instruction group
// What this block does
// [RL1] Plain return pops PC from stack at pointer, decrements pointer, two cycles.
// [RL2] Return-and-skip pops like plain return, then skips next instruction always.
// [RL3] Interrupt return pops PC and restores data pointer X, Y, Z, carry, skip, chain, accumulators.
// [RL4] Upper-page select sets table page high bit for pages 64 to 127.
// [RL5] Set-carry forces carry to 1 in one cycle; only the PC step and clearing chain go with it.
// [RL6] Two-word immediate compare skips next instruction when accumulator equals immediate.
// [RL7] Memory compare skips next instruction when accumulator equals addressed nibble.
// [RL8] External-zero request test skips and clears flag only when enable bit 0.
// [RL9] External-one request test skips and clears flag only when enable bit 0.
// [RL10] Conversion-done test skips and clears flag only when enable bit 0.
// [RL11] External-zero pin test skips on level chosen by select bit; no clear.
// [RL12] External-one pin test skips on level chosen by select bit.
// [RL13] Halt marker test skips when flag is 1, flag left unchanged.
// [RL14] Set-bit sets nibble bit j; port C set; port D bit by Y set only when Y is below 8.
// [RL15] Skipped instruction is fetched, not executed; two-word ones skipped whole.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module rss_exec
	import rss_pkg::*;
#(
	parameter int STACK_D = STACK_DEPTH,
	parameter int MEM_WORDS = 16
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// AXI4-Lite register bus
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	// Pins and event sources
	input wire logic ext_zero_pin_i,
	input wire logic ext_one_pin_i,
	input wire logic ext_zero_req_set_i,
	input wire logic ext_one_req_set_i,
	input wire logic conv_done_set_i,
	// Ports
	output logic port_c_o,
	output logic [7:0] port_d_o
);
	initial begin
		if (STACK_D != 8 || MEM_WORDS < 1 || MEM_WORDS > 16) begin
			$error("rss_exec: unsupported stack depth or memory size");
		end
	end

	// Bus side wires
	logic wr_en, wr_ok, rd_ok;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;

	rss_axi_slave u_bus (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
		.wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
		.bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
		.araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
		.rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
		.wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_strb_o(wr_strb),
		.wr_ok_i(wr_ok), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_ok_i(rd_ok)
	);

	// Architectural state
	exec_state_t state_r, state_nxt;
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [PC_W-1:0] stack_r [STACK_DEPTH];
	logic [PC_W-1:0] stack_nxt [STACK_DEPTH];
	logic [SP_W-1:0] sp_r, sp_nxt;
	logic [3:0] acc_r, acc_nxt, accb_r, accb_nxt;
	logic [5:0] xreg_r, xreg_nxt;
	logic [3:0] yreg_r, yreg_nxt;
	logic [1:0] zreg_r, zreg_nxt;
	logic carry_r, carry_nxt, skip_r, skip_nxt, chain_r, chain_nxt;
	logic page_hi_r, page_hi_nxt, halt_marker_r, halt_marker_nxt;
	logic [3:0] int_ctrl_one_r, int_ctrl_one_nxt, int_ctrl_two_r, int_ctrl_two_nxt;
	logic [3:0] pin_ctrl_one_r, pin_ctrl_one_nxt, pin_ctrl_two_r, pin_ctrl_two_nxt;
	logic ext_zero_req_r, ext_zero_req_nxt, ext_one_req_r, ext_one_req_nxt;
	logic conv_done_r, conv_done_nxt;
	logic [3:0] mem_r [MEM_WORDS];
	logic [3:0] mem_nxt [MEM_WORDS];
	logic port_c_r, port_c_nxt;
	logic [7:0] port_d_r, port_d_nxt;
	// Saved context for the interrupt return
	logic [5:0] sv_x_r, sv_x_nxt;
	logic [3:0] sv_y_r, sv_y_nxt, sv_a_r, sv_a_nxt, sv_b_r, sv_b_nxt;
	logic [1:0] sv_z_r, sv_z_nxt;
	logic sv_cy_r, sv_cy_nxt, sv_sk_r, sv_sk_nxt, sv_ch_r, sv_ch_nxt;
	// Instruction issue register
	logic [OPC_W-1:0] opcode_r, opcode_nxt;
	logic [3:0] imm_r, imm_nxt;
	logic issue_r, issue_nxt, two_word_r, two_word_nxt;
	logic [3:0] mem_rd;
	logic clr_zero, clr_one, clr_conv, is_la, is_lxy;

	assign mem_rd = mem_r[yreg_r[3:0] % MEM_WORDS];
	assign wr_ok = (wr_addr[1:0] == 2'h0) && (wr_addr <= ADDR_PORTS) && (wr_addr != ADDR_STATUS);
	assign rd_ok = (rd_addr[1:0] == 2'h0) && (rd_addr <= ADDR_PORTS);

	always_comb begin
		case (rd_addr)
			ADDR_CTRL: rd_data = {16'h0, two_word_r, issue_r, imm_r, opcode_r};
			ADDR_STATUS: rd_data = {26'h0, state_r == ST_IDLE, page_hi_r, chain_r, skip_r, carry_r, halt_marker_r};
			ADDR_PC: rd_data = {16'h0, sp_r, pc_r};
			ADDR_REGS: rd_data = {12'h0, zreg_r, xreg_r, yreg_r, accb_r, acc_r};
			ADDR_ICTRL: rd_data = {16'h0, pin_ctrl_two_r, pin_ctrl_one_r, int_ctrl_two_r, int_ctrl_one_r};
			ADDR_FLAGS: rd_data = {29'h0, conv_done_r, ext_one_req_r, ext_zero_req_r};
			ADDR_MEM: rd_data = {28'h0, mem_rd};
			ADDR_PORTS: rd_data = {23'h0, port_d_r, port_c_r};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		pc_nxt = pc_r;
		stack_nxt = stack_r;
		sp_nxt = sp_r;
		acc_nxt = acc_r;
		accb_nxt = accb_r;
		xreg_nxt = xreg_r;
		yreg_nxt = yreg_r;
		zreg_nxt = zreg_r;
		carry_nxt = carry_r;
		skip_nxt = skip_r;
		chain_nxt = chain_r;
		page_hi_nxt = page_hi_r;
		halt_marker_nxt = halt_marker_r;
		int_ctrl_one_nxt = int_ctrl_one_r;
		int_ctrl_two_nxt = int_ctrl_two_r;
		pin_ctrl_one_nxt = pin_ctrl_one_r;
		pin_ctrl_two_nxt = pin_ctrl_two_r;
		mem_nxt = mem_r;
		port_c_nxt = port_c_r;
		port_d_nxt = port_d_r;
		sv_x_nxt = sv_x_r;
		sv_y_nxt = sv_y_r;
		sv_z_nxt = sv_z_r;
		sv_a_nxt = sv_a_r;
		sv_b_nxt = sv_b_r;
		sv_cy_nxt = sv_cy_r;
		sv_sk_nxt = sv_sk_r;
		sv_ch_nxt = sv_ch_r;
		opcode_nxt = opcode_r;
		imm_nxt = imm_r;
		issue_nxt = 1'b0;
		two_word_nxt = two_word_r;
		clr_zero = 1'b0;
		clr_one = 1'b0;
		clr_conv = 1'b0;
		is_la = (opcode_r & OP_LA_MASK) == OP_LA_VAL;
		is_lxy = (opcode_r & OP_LXY_MASK) == OP_LXY_VAL;
		unique case (state_r)
			ST_IDLE: begin
				if (issue_r) begin
					pc_nxt = pc_r + (two_word_r ? 13'h0002 : 13'h0001);
					if (skip_r) begin
						// Fetched but not executed; width comes with the issue
						skip_nxt = 1'b0; // [RL15]
					end else if (chain_r && (is_la || is_lxy)) begin
						// Chained loads after the first act as no-ops
						chain_nxt = 1'b1;
					end else begin
						chain_nxt = is_la || is_lxy;
						if (opcode_r == OP_RT || opcode_r == OP_RTS || opcode_r == OP_RTI) begin
							state_nxt = ST_POP; // [RL1]
						end else if (opcode_r == OP_SBK) begin
							page_hi_nxt = 1'b1; // [RL4]
						end else if (opcode_r == OP_SC) begin
							carry_nxt = 1'b1; // [RL5]
						end else if ((opcode_r & OP_SB_MASK) == OP_SB_BASE) begin
							mem_nxt[yreg_r[3:0] % MEM_WORDS][opcode_r[1:0]] = 1'b1; // [RL14]
						end else if (opcode_r == OP_SCP) begin
							port_c_nxt = 1'b1; // [RL14]
						end else if (opcode_r == OP_SD) begin
							if (!yreg_r[3]) begin
								port_d_nxt[yreg_r[2:0]] = 1'b1; // [RL14]
							end
						end else if (opcode_r == OP_SEA) begin
							skip_nxt = acc_r == imm_r; // [RL6]
						end else if (opcode_r == OP_SKIP_IF_ACC_EQUALS_MEM) begin
							skip_nxt = acc_r == mem_rd; // [RL7]
						end else if (opcode_r == OP_SKIP_ON_EXT_ZERO_REQUEST) begin
							if (!int_ctrl_one_r[EXT_ZERO_EN_POS] && ext_zero_req_r) begin
								skip_nxt = 1'b1; // [RL8]
								clr_zero = 1'b1; // [RL8]
							end
						end else if (opcode_r == OP_SKIP_ON_EXT_ONE_REQUEST) begin
							if (!int_ctrl_one_r[EXT_ONE_EN_POS] && ext_one_req_r) begin
								skip_nxt = 1'b1; // [RL9]
								clr_one = 1'b1; // [RL9]
							end
						end else if (opcode_r == OP_SKIP_ON_CONVERSION_DONE) begin
							if (!int_ctrl_two_r[CONV_EN_POS] && conv_done_r) begin
								skip_nxt = 1'b1; // [RL10]
								clr_conv = 1'b1; // [RL10]
							end
						end else if (opcode_r == OP_SKIP_ON_EXT_ZERO_PIN_LEVEL) begin
							skip_nxt = ext_zero_pin_i == pin_ctrl_one_r[LEVEL_SEL_POS]; // [RL11]
						end else if (opcode_r == OP_SKIP_ON_EXT_ONE_PIN_LEVEL) begin
							skip_nxt = ext_one_pin_i == pin_ctrl_two_r[LEVEL_SEL_POS]; // [RL12]
						end else if (opcode_r == OP_SKIP_ON_HALT_MARKER) begin
							skip_nxt = halt_marker_r; // [RL13]
						end else if (is_la) begin
							acc_nxt = opcode_r[3:0];
						end else if (is_lxy) begin
							xreg_nxt = {2'h0, opcode_r[7:4]};
							yreg_nxt = opcode_r[3:0];
						end
					end
				end
			end
			ST_POP: begin
				// Second cycle of a return: pop and unwind
				pc_nxt = stack_r[sp_r]; // [RL1]
				sp_nxt = sp_r - 3'h1; // [RL1]
				state_nxt = ST_IDLE;
				if (opcode_r == OP_RTS) begin
					skip_nxt = 1'b1; // [RL2]
				end else if (opcode_r == OP_RTI) begin
					xreg_nxt = sv_x_r; // [RL3]
					yreg_nxt = sv_y_r;
					zreg_nxt = sv_z_r;
					carry_nxt = sv_cy_r;
					skip_nxt = sv_sk_r;
					chain_nxt = sv_ch_r;
					acc_nxt = sv_a_r;
					accb_nxt = sv_b_r;
				end
			end
			ST_SKIP2: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// Software writes; the issue register starts an instruction
		if (wr_en && wr_ok) begin
			unique case (wr_addr)
				ADDR_CTRL: begin
					if (state_r == ST_IDLE && !issue_r) begin
						opcode_nxt = wr_data[9:0];
						imm_nxt = wr_data[13:10];
						two_word_nxt = wr_data[15];
						issue_nxt = 1'b1;
					end
				end
				ADDR_PC: begin
					pc_nxt = wr_data[12:0];
					sp_nxt = wr_data[15:13];
					stack_nxt[wr_data[15:13]] = wr_data[28:16];
				end
				ADDR_REGS: begin
					acc_nxt = wr_data[3:0];
					accb_nxt = wr_data[7:4];
					yreg_nxt = wr_data[11:8];
					xreg_nxt = wr_data[17:12];
					zreg_nxt = wr_data[19:18];
					sv_a_nxt = wr_data[23:20];
					sv_b_nxt = wr_data[27:24];
					sv_cy_nxt = wr_data[28];
					sv_sk_nxt = wr_data[29];
					sv_ch_nxt = wr_data[30];
					halt_marker_nxt = wr_data[31];
				end
				ADDR_ICTRL: begin
					int_ctrl_one_nxt = wr_data[3:0];
					int_ctrl_two_nxt = wr_data[7:4];
					pin_ctrl_one_nxt = wr_data[11:8];
					pin_ctrl_two_nxt = wr_data[15:12];
					sv_x_nxt = wr_data[21:16];
					sv_y_nxt = wr_data[25:22];
					sv_z_nxt = wr_data[27:26];
				end
				ADDR_MEM: mem_nxt[yreg_r[3:0] % MEM_WORDS] = wr_data[3:0];
				ADDR_PORTS: begin
					port_c_nxt = wr_data[0];
					port_d_nxt = wr_data[8:1];
				end
				default: begin
				end
			endcase
		end
		// Set wins over clear so no request is lost
		ext_zero_req_nxt = ext_zero_req_set_i || (ext_zero_req_r && !clr_zero);
		ext_one_req_nxt = ext_one_req_set_i || (ext_one_req_r && !clr_one);
		conv_done_nxt = conv_done_set_i || (conv_done_r && !clr_conv);
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= ST_IDLE;
			pc_r <= PC_RST;
			stack_r <= '{default: 13'h0000};
			sp_r <= SP_RST;
			acc_r <= 4'h0;
			accb_r <= 4'h0;
			xreg_r <= 6'h00;
			yreg_r <= 4'h0;
			zreg_r <= 2'h0;
			carry_r <= 1'b0;
			skip_r <= 1'b0;
			chain_r <= 1'b0;
			page_hi_r <= 1'b0;
			halt_marker_r <= 1'b0;
			int_ctrl_one_r <= 4'h0;
			int_ctrl_two_r <= 4'h0;
			pin_ctrl_one_r <= 4'h0;
			pin_ctrl_two_r <= 4'h0;
			ext_zero_req_r <= 1'b0;
			ext_one_req_r <= 1'b0;
			conv_done_r <= 1'b0;
			mem_r <= '{default: 4'h0};
			port_c_r <= 1'b0;
			port_d_r <= 8'h00;
			sv_x_r <= 6'h00;
			sv_y_r <= 4'h0;
			sv_z_r <= 2'h0;
			sv_a_r <= 4'h0;
			sv_b_r <= 4'h0;
			sv_cy_r <= 1'b0;
			sv_sk_r <= 1'b0;
			sv_ch_r <= 1'b0;
			opcode_r <= 10'h000;
			imm_r <= 4'h0;
			issue_r <= 1'b0;
			two_word_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			stack_r <= stack_nxt;
			sp_r <= sp_nxt;
			acc_r <= acc_nxt;
			accb_r <= accb_nxt;
			xreg_r <= xreg_nxt;
			yreg_r <= yreg_nxt;
			zreg_r <= zreg_nxt;
			carry_r <= carry_nxt;
			skip_r <= skip_nxt;
			chain_r <= chain_nxt;
			page_hi_r <= page_hi_nxt;
			halt_marker_r <= halt_marker_nxt;
			int_ctrl_one_r <= int_ctrl_one_nxt;
			int_ctrl_two_r <= int_ctrl_two_nxt;
			pin_ctrl_one_r <= pin_ctrl_one_nxt;
			pin_ctrl_two_r <= pin_ctrl_two_nxt;
			ext_zero_req_r <= ext_zero_req_nxt;
			ext_one_req_r <= ext_one_req_nxt;
			conv_done_r <= conv_done_nxt;
			mem_r <= mem_nxt;
			port_c_r <= port_c_nxt;
			port_d_r <= port_d_nxt;
			sv_x_r <= sv_x_nxt;
			sv_y_r <= sv_y_nxt;
			sv_z_r <= sv_z_nxt;
			sv_a_r <= sv_a_nxt;
			sv_b_r <= sv_b_nxt;
			sv_cy_r <= sv_cy_nxt;
			sv_sk_r <= sv_sk_nxt;
			sv_ch_r <= sv_ch_nxt;
			opcode_r <= opcode_nxt;
			imm_r <= imm_nxt;
			issue_r <= issue_nxt;
			two_word_r <= two_word_nxt;
		end
	end

	assign port_c_o = port_c_r;
	assign port_d_o = port_d_r;
endmodule

/* core/rss_pkg.sv */
// Package: opcodes, register layout and constants for the return/set/skip unit
package rss_pkg;
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 3;
	localparam logic [SP_W-1:0] SP_RST = 3'h7;
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam int OPC_W = 10;
	// Opcodes
	localparam logic [9:0] OP_RT = 10'h044;
	localparam logic [9:0] OP_RTI = 10'h046;
	localparam logic [9:0] OP_RTS = 10'h045;
	localparam logic [9:0] OP_SB_BASE = 10'h05c;
	localparam logic [9:0] OP_SBK = 10'h041;
	localparam logic [9:0] OP_SC = 10'h007;
	localparam logic [9:0] OP_SCP = 10'h28d;
	localparam logic [9:0] OP_SD = 10'h015;
	localparam logic [9:0] OP_SEA = 10'h025;
	localparam logic [9:0] OP_SKIP_IF_ACC_EQUALS_MEM = 10'h026;
	localparam logic [9:0] OP_SKIP_ON_EXT_ZERO_REQUEST = 10'h038;
	localparam logic [9:0] OP_SKIP_ON_EXT_ONE_REQUEST = 10'h039;
	localparam logic [9:0] OP_SKIP_ON_CONVERSION_DONE = 10'h287;
	localparam logic [9:0] OP_SKIP_ON_EXT_ZERO_PIN_LEVEL = 10'h03a;
	localparam logic [9:0] OP_SKIP_ON_EXT_ONE_PIN_LEVEL = 10'h03b;
	localparam logic [9:0] OP_SKIP_ON_HALT_MARKER = 10'h003;
	localparam logic [9:0] OP_LA_MASK = 10'h3f0;
	localparam logic [9:0] OP_LA_VAL = 10'h070;
	localparam logic [9:0] OP_LXY_MASK = 10'h300;
	localparam logic [9:0] OP_LXY_VAL = 10'h300;
	localparam logic [9:0] OP_SB_MASK = 10'h3fc;
	// Bit positions in control registers
	localparam int EXT_ZERO_EN_POS = 0;
	localparam int EXT_ONE_EN_POS = 1;
	localparam int CONV_EN_POS = 2;
	localparam int LEVEL_SEL_POS = 2;
	// AXI4-Lite register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PC = 8'h08;
	localparam logic [7:0] ADDR_REGS = 8'h0c;
	localparam logic [7:0] ADDR_ICTRL = 8'h10;
	localparam logic [7:0] ADDR_FLAGS = 8'h14;
	localparam logic [7:0] ADDR_MEM = 8'h18;
	localparam logic [7:0] ADDR_PORTS = 8'h1c;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_POP, ST_SKIP2} exec_state_t;
endpackage

/* core/rss_axi_slave.sv */
// AXI4-Lite slave front end: decodes one write and one read at a time
`timescale 1ns/100ps
module rss_axi_slave
	import rss_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Write channels
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	// Read channels
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	// Core side
	output logic wr_en_o,
	output logic [7:0] wr_addr_o,
	output logic [31:0] wr_data_o,
	output logic [3:0] wr_strb_o,
	input wire logic wr_ok_i,
	output logic [7:0] rd_addr_o,
	input wire logic [31:0] rd_data_i,
	input wire logic rd_ok_i
);
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt, bvalid_r, bvalid_nxt;
	logic [7:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic do_wr;

	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		do_wr = aw_have_r && w_have_r && !bvalid_r;
		if (awvalid_i && !aw_have_r) begin
			aw_have_nxt = 1'b1;
			awaddr_nxt = awaddr_i;
		end
		if (wvalid_i && !w_have_r) begin
			w_have_nxt = 1'b1;
			wdata_nxt = wdata_i;
			wstrb_nxt = wstrb_i;
		end
		if (do_wr) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_r && bready_i) begin
			bvalid_nxt = 1'b0;
		end
		if (arvalid_i && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_ok_i ? rd_data_i : 32'h0000_0000;
			rresp_nxt = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && rready_i) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Ready only while the holding slot is empty
	assign awready_o = !aw_have_r;
	assign wready_o = !w_have_r;
	assign arready_o = !rvalid_r;
	assign bvalid_o = bvalid_r;
	assign bresp_o = bresp_r;
	assign rvalid_o = rvalid_r;
	assign rresp_o = rresp_r;
	assign rdata_o = rdata_r;
	assign wr_en_o = do_wr;
	assign wr_addr_o = awaddr_r;
	assign wr_data_o = wdata_r;
	assign wr_strb_o = wstrb_r;
	assign rd_addr_o = araddr_i;
endmodule

/* dv/rss_exec_sva.sv */
// Checker for bus handshakes and port behaviour of the execution unit
`timescale 1ns/100ps
module rss_exec_sva
	import rss_pkg::*;
#(
	parameter int STACK_D = STACK_DEPTH,
	parameter int MEM_WORDS = 16
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Register bus
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	input wire logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	input wire logic wready_o,
	input wire logic [1:0] bresp_o,
	input wire logic bvalid_o,
	input wire logic bready_i,
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	input wire logic arready_o,
	input wire logic [31:0] rdata_o,
	input wire logic [1:0] rresp_o,
	input wire logic rvalid_o,
	input wire logic rready_i,
	// Pins and ports
	input wire logic ext_zero_pin_i,
	input wire logic ext_one_pin_i,
	input wire logic ext_zero_req_set_i,
	input wire logic ext_one_req_set_i,
	input wire logic conv_done_set_i,
	input wire logic port_c_o,
	input wire logic [7:0] port_d_o
);
	logic [3:0] age_r;
	// Cycles since the last accepted write beat; ports only move on an issued instruction or a write to the port register
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			age_r <= 4'hf;
		end else if (wvalid_i && wready_o) begin
			age_r <= 4'h0;
		end else if (age_r != 4'hf) begin
			age_r <= age_r + 4'h1;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	chk_bvalid_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
		else $error("write response dropped early");
	chk_rvalid_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
		else $error("read data dropped early");
	chk_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
		else $error("read answer late");
	chk_read_single: assert property (rvalid_o |-> !arready_o)
		else $error("second read accepted");
	chk_read_release: assert property (rvalid_o && rready_i |=> !rvalid_o)
		else $error("read answer repeated");
	chk_write_answer: assert property (awvalid_i && awready_o && wvalid_i && wready_o |-> ##[1:3] bvalid_o)
		else $error("write answer late");
	chk_port_c_set: assert property (!$fell(port_c_o))
		else $error("port c cleared");
	chk_port_d_set: assert property (($past(port_d_o) & ~port_d_o) == 8'h00)
		else $error("port d bit cleared");
	chk_port_cause: assert property ($rose(port_c_o) || $changed(port_d_o) |-> age_r <= 4'h6)
		else $error("port moved without instruction");
	cover property ($rose(port_c_o));
	cover property ($changed(port_d_o));
	cover property (bvalid_o && bresp_o == RESP_SLVERR);
	cover property (rvalid_o && rresp_o == RESP_SLVERR);
endmodule
bind rss_exec rss_exec_sva #(.STACK_D(STACK_D), .MEM_WORDS(MEM_WORDS)) chk_u (.*);

/* dv/rss_exec_tb.sv */
// Testbench: instruction scenarios issued over the register bus
`timescale 1ns/100ps
module rss_exec_tb
	import rss_pkg::*;
;
	logic ref_clk_i, nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, port_c_o;
	logic [7:0] awaddr_i, araddr_i, port_d_o;
	logic [31:0] wdata_i, rdata_o, rdat;
	logic [3:0] wstrb_i;
	logic [1:0] bresp_o, rresp_o, resp, pin;
	logic [2:0] rq;
	logic [12:0] p;
	int error_cnt, num_checks;
	logic [9:0] rop [3] = '{OP_SKIP_ON_EXT_ZERO_REQUEST, OP_SKIP_ON_EXT_ONE_REQUEST, OP_SKIP_ON_CONVERSION_DONE};
	logic [31:0] ren [3] = '{32'h1, 32'h2, 32'h40};
	wire ext_zero_pin_i = pin[0];
	wire ext_one_pin_i = pin[1];
	wire ext_zero_req_set_i = rq[0];
	wire ext_one_req_set_i = rq[1];
	wire conv_done_set_i = rq[2];
	rss_exec dut_u (.*);
	always #25 ref_clk_i = !ref_clk_i;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		awaddr_i <= a;
		wdata_i <= d;
		awvalid_i <= 1'h1;
		wvalid_i <= 1'h1;
		bready_i <= 1'h1;
		do begin
			@(posedge ref_clk_i);
			if (awready_o) awvalid_i <= 1'h0;
			if (wready_o) wvalid_i <= 1'h0;
		end while (bvalid_o !== 1'h1);
		resp = bresp_o;
		bready_i <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk_i);
		araddr_i <= a;
		arvalid_i <= 1'h1;
		rready_i <= 1'h1;
		do begin
			@(posedge ref_clk_i);
			if (arready_o) arvalid_i <= 1'h0;
		end while (rvalid_o !== 1'h1);
		rdat = rdata_o;
		resp = rresp_o;
		rready_i <= 1'h0;
	endtask
	task automatic run(input logic [31:0] op);
		int n;
		wr(ADDR_CTRL, op);
		n = 0;
		do begin
			rd(ADDR_STATUS);
			n++;
		end while (rdat[5] !== 1'h1 && n < 20);
		// A unit that never returns to idle counts as a mismatch
		chk("idle", {31'h0, rdat[5]}, 32'h1);
	endtask
	// Skipped instruction is a set-bit on a cleared nibble, so its effect shows
	task automatic skp(input logic [31:0] op, input logic e);
		run(op);
		rd(ADDR_STATUS);
		chk("skip", {31'h0, rdat[2]}, {31'h0, e});
		wr(ADDR_MEM, 32'h0);
		run(32'(OP_SB_BASE) | 32'h3);
		rd(ADDR_MEM);
		chk("skipped", rdat, e ? 32'h0 : 32'h8);
	endtask
	initial begin
		{ref_clk_i, nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
		{awaddr_i, araddr_i, wdata_i, rq, pin} = '0;
		wstrb_i = 4'hf;
		repeat (2) @(posedge ref_clk_i);
		nrst_i <= 1'h1;
		rd(ADDR_PORTS);
		chk("ports", rdat, 32'h0);
		rd(8'h20);
		chk("unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(ADDR_STATUS, 32'h1);
		chk("ro write", {30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(ADDR_REGS, 32'h5);
		run(32'(OP_SC));
		rd(ADDR_STATUS);
		chk("carry", {31'h0, rdat[1]}, 32'h1);
		rd(ADDR_REGS);
		chk("regs", rdat, 32'h5);
		$display("test bus and carry done");
		rd(ADDR_PC);
		p = rdat[12:0];
		skp({16'h0, 1'h1, 1'h0, 4'h5, OP_SEA}, 1'h1);
		skp({16'h0, 1'h1, 1'h0, 4'h6, OP_SEA}, 1'h0);
		rd(ADDR_PC);
		chk("pc", {19'h0, rdat[12:0]}, {19'h0, p + 13'h6});
		wr(ADDR_MEM, 32'h5);
		skp(32'(OP_SKIP_IF_ACC_EQUALS_MEM), 1'h1);
		skp(32'(OP_SKIP_IF_ACC_EQUALS_MEM), 1'h0);
		$display("test compare done");
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_ICTRL, 32'h0);
			skp(32'(rop[i]), 1'h0);
			rq[i] <= 1'h1;
			@(posedge ref_clk_i);
			rq <= 3'h0;
			wr(ADDR_ICTRL, ren[i]);
			skp(32'(rop[i]), 1'h0);
			rd(ADDR_FLAGS);
			chk("flag kept", rdat, 32'h1 << i);
			wr(ADDR_ICTRL, 32'h0);
			skp(32'(rop[i]), 1'h1);
			rd(ADDR_FLAGS);
			chk("flag clear", rdat, 32'h0);
		end
		for (int k = 0; k < 2; k++) begin
			for (int v = 0; v < 4; v++) begin
				wr(ADDR_ICTRL, 32'(v[1]) << (k ? 14 : 10));
				pin <= 2'(v[0]) << k;
				skp(k ? 32'(OP_SKIP_ON_EXT_ONE_PIN_LEVEL) : 32'(OP_SKIP_ON_EXT_ZERO_PIN_LEVEL), v[0] == v[1]);
			end
		end
		wr(ADDR_REGS, 32'h8000_0000);
		skp(32'(OP_SKIP_ON_HALT_MARKER), 1'h1);
		rd(ADDR_STATUS);
		chk("halt kept", {31'h0, rdat[0]}, 32'h1);
		// Skipped two-word compare would match if run, so a wrong skip shows
		run(32'(OP_SKIP_ON_HALT_MARKER));
		rd(ADDR_PC);
		p = rdat[12:0];
		run({16'h0, 1'h1, 1'h0, 4'h0, OP_SEA});
		rd(ADDR_STATUS);
		chk("two word skip", {31'h0, rdat[2]}, 32'h0);
		rd(ADDR_PC);
		chk("two word pc", {19'h0, rdat[12:0]}, {19'h0, p + 13'h2});
		wr(ADDR_REGS, 32'h0);
		skp(32'(OP_SKIP_ON_HALT_MARKER), 1'h0);
		$display("test flag skips done");
		wr(ADDR_PC, 32'h0123_a000);
		run(32'(OP_RT));
		rd(ADDR_PC);
		chk("return", {16'h0, rdat[15:0]}, 32'h8123);
		wr(ADDR_PC, 32'h0200_a000);
		skp(32'(OP_RTS), 1'h1);
		wr(ADDR_REGS, 32'h0390_0000);
		wr(ADDR_PC, 32'h0040_a000);
		run(32'(OP_RTI));
		rd(ADDR_REGS);
		chk("restore acc", {24'h0, rdat[7:0]}, 32'h39);
		rd(ADDR_STATUS);
		chk("restore carry", {31'h0, rdat[1]}, 32'h0);
		rd(ADDR_PC);
		chk("rti pc", {16'h0, rdat[15:0]}, 32'h8040);
		$display("test returns done");
		run(32'(OP_SBK));
		rd(ADDR_STATUS);
		chk("page", {31'h0, rdat[4]}, 32'h1);
		wr(ADDR_REGS, 32'h0);
		wr(ADDR_MEM, 32'h0);
		for (int j = 0; j < 4; j++) begin
			run(32'(OP_SB_BASE) | 32'(j));
		end
		rd(ADDR_MEM);
		chk("mem bits", rdat, 32'hf);
		run(32'(OP_SCP));
		wr(ADDR_REGS, 32'h300);
		run(32'(OP_SD));
		wr(ADDR_REGS, 32'h900);
		run(32'(OP_SD));
		rd(ADDR_PORTS);
		chk("ports set", rdat, 32'h11);
		chk("port pins", {23'h0, port_d_o, port_c_o}, 32'h11);
		$display("test set ops done");
		complete_run();
	end
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		error_cnt++;
		complete_run();
	end
endmodule
